// File: design/srctl_regs.svh
// Register offsets, field positions and reset values for the standby RAM control.
// Assumes an 8-bit register port and a 16-bit processor address space.
// Summary of operation
// - Enable clear sends RAM addresses to external bus
// - Enable bit is bit 6, read/write
// - Reset release sets enable if standby good
// - RAM mapped only if enabled and not mode 3
// - Disabling never alters the RAM contents
// - Valid flag is bit 7, survives reset
// - Flag cleared by write zero or supply low
// - Only a software write of one sets flag
// - Supply low holds flag cleared, even over writes
// - Low 64 bytes, enable and flag standby powered
`ifndef SRCTL_REGS_SVH
`define SRCTL_REGS_SVH

`define SRCTL_RAM_CONTROL_ADDR 8'h14
`define SRCTL_ENABLE_BIT       6
`define SRCTL_VALID_BIT        7
`define SRCTL_UNUSED_READ      6'h00
`define SRCTL_ENABLE_RESET     1'h0
`define SRCTL_VALID_RESET      1'h0
`define SRCTL_RAM_FIRST        16'h0080
`define SRCTL_RAM_LAST         16'h00ff
`define SRCTL_STBY_LAST        16'h00bf
`define SRCTL_MODE_NO_RAM      3'h3
`define SRCTL_RAM_WORDS        128
`define SRCTL_SYNC_STAGES      3

`endif

// File: design/srctl_pkg.sv
// Types used by the standby RAM control top level; the address decoder does not use them.
// Assumes the constants header sits on the include path.
package srctl_pkg;

   typedef enum logic
   {
      SRCTL_PH_RESET,
      SRCTL_PH_RUN
   } srctl_phase_t;

   typedef struct packed
   {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } srctl_mem_req_t;

   typedef struct packed
   {
      logic valid;
      logic enable;
   } srctl_ctl_t;

endpackage : srctl_pkg

// File: design/srctl_decode.sv
// Internal RAM address decoder for the standby RAM control.
// Assumes the enable bit and latched mode come from registers of the caller.
`timescale 1ns/1ps
`include "srctl_regs.svh"

module srctl_decode
(
   input  wire logic [15:0] addr_i,
   input  wire logic        ram_enable_i,
   input  wire logic [2:0]  mode_i,
   output logic             ram_live_o,
   output logic             int_hit_o,
   output logic             stby_hit_o
);

   function automatic logic srctl_in_range
   (
      input logic [15:0] a,
      input logic [15:0] lo,
      input logic [15:0] hi
   );
      srctl_in_range = (a >= lo) && (a <= hi);
   endfunction : srctl_in_range

   always_comb
   begin
      // Mode 3 excludes the array whatever the enable bit holds
      ram_live_o = ram_enable_i && (mode_i != `SRCTL_MODE_NO_RAM);
      // A cleared enable makes the whole range decode as external
      int_hit_o  = ram_live_o &&
                   srctl_in_range(addr_i, `SRCTL_RAM_FIRST, `SRCTL_RAM_LAST);
      stby_hit_o = int_hit_o &&
                   srctl_in_range(addr_i, `SRCTL_RAM_FIRST, `SRCTL_STBY_LAST);
   end

endmodule : srctl_decode

// File: design/srctl_top.sv
// Standby RAM control: control register, internal RAM array and its routing.
// Assumes a one-cycle register port, pins asynchronous to CLOCK_I, and a
// standby power-on reset that is low only when standby power first appears.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "srctl_regs.svh"

module srctl_top
#(
   parameter int RAM_WORDS = `SRCTL_RAM_WORDS
)
(
   input  wire logic        CLOCK_I,
   input  wire logic        RST_N_I,
   input  wire logic        STBY_POR_N_I,
   input  wire logic [7:0]  REG_ADDR_I,
   input  wire logic [7:0]  REG_WDATA_I,
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   output logic      [7:0]  REG_RDATA_O,
   input  wire logic [15:0] MEM_ADDR_I,
   input  wire logic [7:0]  MEM_WDATA_I,
   input  wire logic        MEM_WR_I,
   input  wire logic        MEM_RD_I,
   output logic      [7:0]  MEM_RDATA_O,
   output logic             MEM_INT_HIT_O,
   output logic             MEM_STBY_HIT_O,
   output logic      [15:0] EXT_ADDR_O,
   output logic      [7:0]  EXT_WDATA_O,
   output logic             EXT_WR_O,
   output logic             EXT_RD_O,
   input  wire logic        STBY_GOOD_I,
   input  wire logic        STBY_LOW_I,
   input  wire logic [2:0]  MODE_PINS_I,
   output logic             RAM_ENABLE_O,
   output logic             STANDBY_VALID_O,
   output logic      [2:0]  MODE_O
);

   localparam int PIN_W  = 5;
   localparam int IDX_W  = $clog2(RAM_WORDS);

   // Pin synchroniser, three stages per pin
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] sync1_reg;
   logic [PIN_W-1:0] sync1_next;
   logic [PIN_W-1:0] sync2_reg;
   logic [PIN_W-1:0] sync2_next;
   logic [PIN_W-1:0] sync3_reg;
   logic [PIN_W-1:0] sync3_next;
   logic [PIN_W-1:0] pin_filt_reg;
   logic [PIN_W-1:0] pin_filt_next;

   logic             good_f;
   logic             low_f;
   logic [2:0]       mode_f;

   // Phase and mode
   srctl_pkg::srctl_phase_t phase_reg;
   srctl_pkg::srctl_phase_t phase_next;
   logic [2:0]       mode_reg;
   logic [2:0]       mode_next;
   logic             release_evt;

   // Control register
   srctl_pkg::srctl_ctl_t ctl_reg;
   srctl_pkg::srctl_ctl_t ctl_next;
   logic             ctl_wr;
   logic             ctl_rd;
   logic [7:0]       reg_rdata_reg;
   logic [7:0]       reg_rdata_next;

   // Memory path
   srctl_pkg::srctl_mem_req_t req;
   srctl_pkg::srctl_mem_req_t ext_reg;
   srctl_pkg::srctl_mem_req_t ext_next;
   logic [7:0]       mem_rdata_reg;
   logic [7:0]       mem_rdata_next;
   logic             int_hit_reg;
   logic             int_hit_next;
   logic             stby_hit_reg;
   logic             stby_hit_next;
   logic             int_hit;
   logic             stby_hit;
   logic             ram_we;
   logic [IDX_W-1:0] ram_idx;

   // No reset on the array: contents outlive enable changes and resets
   logic [7:0]       ram_mem [RAM_WORDS];

   assign pins_raw = {MODE_PINS_I, STBY_LOW_I, STBY_GOOD_I};

   // The chain belongs to the standby domain so the supply state is
   // already filtered when the main reset releases
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++)
      begin : g_sync
         always_comb
         begin
            sync1_next[gi] = pins_raw[gi];
            sync2_next[gi] = sync1_reg[gi];
            sync3_next[gi] = sync2_reg[gi];
            // A change counts only once stages two and three agree
            if (sync2_reg[gi] == sync3_reg[gi])
            begin
               pin_filt_next[gi] = sync3_reg[gi];
            end
            else
            begin
               pin_filt_next[gi] = pin_filt_reg[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge CLOCK_I)
   begin
      if (!STBY_POR_N_I)
      begin
         sync1_reg    <= '0;
         sync2_reg    <= '0;
         sync3_reg    <= '0;
         pin_filt_reg <= '0;
      end
      else
      begin
         sync1_reg    <= sync1_next;
         sync2_reg    <= sync2_next;
         sync3_reg    <= sync3_next;
         pin_filt_reg <= pin_filt_next;
      end
   end

   assign good_f = pin_filt_reg[0];
   assign low_f  = pin_filt_reg[1];
   assign mode_f = pin_filt_reg[4:2];

   // Reset phase tracking and mode latch
   always_comb
   begin
      release_evt = (phase_reg == srctl_pkg::SRCTL_PH_RESET) && RST_N_I;
      phase_next  = phase_reg;
      mode_next   = mode_reg;
      unique case (phase_reg)
         srctl_pkg::SRCTL_PH_RESET:
         begin
            // Mode follows the pins while held; frozen at the release
            mode_next = mode_f;
            if (RST_N_I)
            begin
               phase_next = srctl_pkg::SRCTL_PH_RUN;
            end
         end
         srctl_pkg::SRCTL_PH_RUN:
         begin
            phase_next = srctl_pkg::SRCTL_PH_RUN;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_N_I)
      begin
         phase_reg <= srctl_pkg::SRCTL_PH_RESET;
         mode_reg  <= mode_f;
      end
      else
      begin
         phase_reg <= phase_next;
         mode_reg  <= mode_next;
      end
   end

   // Control register; the main reset leaves it alone, only the
   // standby power-on reset gives it a value
   assign ctl_wr = REG_WR_I && RST_N_I && (REG_ADDR_I == `SRCTL_RAM_CONTROL_ADDR);
   assign ctl_rd = REG_RD_I && RST_N_I && (REG_ADDR_I == `SRCTL_RAM_CONTROL_ADDR);

   always_comb
   begin
      ctl_next = ctl_reg;
      if (ctl_wr)
      begin
         ctl_next.enable = REG_WDATA_I[`SRCTL_ENABLE_BIT];
         // Writes are the only path that can raise the flag
         ctl_next.valid  = REG_WDATA_I[`SRCTL_VALID_BIT];
      end
      if (release_evt && good_f)
      begin
         ctl_next.enable = 1'h1;
      end
      // Supply low beats a same-cycle write of one
      if (low_f)
      begin
         ctl_next.valid = 1'h0;
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!STBY_POR_N_I)
      begin
         ctl_reg.enable <= `SRCTL_ENABLE_RESET;
         ctl_reg.valid  <= `SRCTL_VALID_RESET;
      end
      else
      begin
         // RST_N_I deliberately absent here
         ctl_reg <= ctl_next;
      end
   end

   // Read data valid in the cycle after the strobe only
   always_comb
   begin
      reg_rdata_next = 8'h00;
      if (ctl_rd)
      begin
         reg_rdata_next = {ctl_reg.valid, ctl_reg.enable, `SRCTL_UNUSED_READ};
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_N_I)
      begin
         reg_rdata_reg <= 8'h00;
      end
      else
      begin
         reg_rdata_reg <= reg_rdata_next;
      end
   end

   // Memory access routing
   always_comb
   begin
      req.addr  = MEM_ADDR_I;
      req.wdata = MEM_WDATA_I;
      req.wr    = MEM_WR_I && RST_N_I;
      req.rd    = MEM_RD_I && RST_N_I;
   end

   srctl_decode u_decode
   (
      .addr_i       (req.addr),
      .ram_enable_i (ctl_reg.enable),
      .mode_i       (mode_reg),
      .ram_live_o   (),
      .int_hit_o    (int_hit),
      .stby_hit_o   (stby_hit)
   );

   assign ram_idx = req.addr[IDX_W-1:0];
   assign ram_we  = req.wr && int_hit;

   always_comb
   begin
      mem_rdata_next = 8'h00;
      int_hit_next   = (req.wr || req.rd) && int_hit;
      stby_hit_next  = (req.wr || req.rd) && stby_hit;
      ext_next.addr  = req.addr;
      ext_next.wdata = req.wdata;
      // Misses go out one cycle later, aligned with the read data slot
      ext_next.wr    = req.wr && !int_hit;
      ext_next.rd    = req.rd && !int_hit;
      if (req.rd && int_hit)
      begin
         mem_rdata_next = ram_mem[ram_idx];
      end
   end

   // Array written only on an internal hit; enable changes never touch it
   always_ff @(posedge CLOCK_I)
   begin
      if (ram_we)
      begin
         ram_mem[ram_idx] <= req.wdata;
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_N_I)
      begin
         mem_rdata_reg <= 8'h00;
         int_hit_reg   <= 1'h0;
         stby_hit_reg  <= 1'h0;
         ext_reg       <= '0;
      end
      else
      begin
         mem_rdata_reg <= mem_rdata_next;
         int_hit_reg   <= int_hit_next;
         stby_hit_reg  <= stby_hit_next;
         ext_reg       <= ext_next;
      end
   end

   // Outputs, all from flip-flops
   assign REG_RDATA_O     = reg_rdata_reg;
   assign MEM_RDATA_O     = mem_rdata_reg;
   assign MEM_INT_HIT_O   = int_hit_reg;
   assign MEM_STBY_HIT_O  = stby_hit_reg;
   assign EXT_ADDR_O      = ext_reg.addr;
   assign EXT_WDATA_O     = ext_reg.wdata;
   assign EXT_WR_O        = ext_reg.wr;
   assign EXT_RD_O        = ext_reg.rd;
   assign RAM_ENABLE_O    = ctl_reg.enable;
   assign STANDBY_VALID_O = ctl_reg.valid;
   assign MODE_O          = mode_reg;

endmodule : srctl_top

// File: tb/srctl_checker.sv
// Port assertions for the standby RAM control.
// Assumes one clock domain and the synchronous active-low main reset.
`timescale 1ns/1ps
module srctl_checker
(
   input wire logic        CLOCK_I,
   input wire logic        RST_N_I,
   input wire logic [7:0]  REG_ADDR_I,
   input wire logic [7:0]  REG_WDATA_I,
   input wire logic        REG_WR_I,
   input wire logic        REG_RD_I,
   input wire logic [7:0]  REG_RDATA_O,
   input wire logic [15:0] MEM_ADDR_I,
   input wire logic        MEM_WR_I,
   input wire logic        MEM_RD_I,
   input wire logic        MEM_INT_HIT_O,
   input wire logic        MEM_STBY_HIT_O,
   input wire logic        EXT_WR_O,
   input wire logic        EXT_RD_O,
   input wire logic        STBY_LOW_I,
   input wire logic        RAM_ENABLE_O,
   input wire logic        STANDBY_VALID_O,
   input wire logic [2:0]  MODE_O
);
   logic wr_ctl;
   assign wr_ctl = REG_WR_I && REG_ADDR_I == 8'h14;
   default clocking dc @(posedge CLOCK_I);
   endclocking
   default disable iff (!RST_N_I);
   AST_RD_CTL: assert property (REG_RD_I && REG_ADDR_I == 8'h14 |=>
      REG_RDATA_O == {$past(STANDBY_VALID_O), $past(RAM_ENABLE_O), 6'h00})
      else $error("control read data wrong");
   AST_EN_WR: assert property (wr_ctl && $past(RST_N_I) |=>
      RAM_ENABLE_O == $past(REG_WDATA_I[6])) else $error("enable write lost");
   AST_EN_RISE: assert property ($rose(RAM_ENABLE_O) |->
      $past(wr_ctl) || !$past(RST_N_I, 2)) else $error("enable set without cause");
   AST_FLAG_RISE: assert property ($rose(STANDBY_VALID_O) |->
      $past(wr_ctl && REG_WDATA_I[7])) else $error("flag set without write");
   AST_FLAG_LOW: assert property (STBY_LOW_I [*6] |=> !STANDBY_VALID_O)
      else $error("flag not held clear");
   AST_MISS: assert property (MEM_WR_I && !RAM_ENABLE_O |=>
      EXT_WR_O && !MEM_INT_HIT_O) else $error("disabled write not external");
   AST_MODE3: assert property (MEM_RD_I && MODE_O == 3'h3 |=>
      EXT_RD_O && !MEM_INT_HIT_O) else $error("mode 3 read not external");
   AST_HIT: assert property (MEM_RD_I && MEM_ADDR_I[15:7] == 9'h001 && RAM_ENABLE_O
      && MODE_O != 3'h3 |=> MEM_INT_HIT_O && !EXT_RD_O
      && MEM_STBY_HIT_O == !$past(MEM_ADDR_I[6])) else $error("internal hit wrong");
endmodule : srctl_checker

bind srctl_top srctl_checker u_chk
(
   .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
   .REG_RDATA_O(REG_RDATA_O), .MEM_ADDR_I(MEM_ADDR_I), .MEM_WR_I(MEM_WR_I),
   .MEM_RD_I(MEM_RD_I), .MEM_INT_HIT_O(MEM_INT_HIT_O), .MEM_STBY_HIT_O(MEM_STBY_HIT_O),
   .EXT_WR_O(EXT_WR_O), .EXT_RD_O(EXT_RD_O), .STBY_LOW_I(STBY_LOW_I),
   .RAM_ENABLE_O(RAM_ENABLE_O), .STANDBY_VALID_O(STANDBY_VALID_O), .MODE_O(MODE_O)
);

// File: tb/srctl_ext_model.sv
// External memory stand-in recording writes routed off chip.
// Assumes one-cycle write pulses on the external port.
`timescale 1ns/1ps
module srctl_ext_model
(
   input  wire logic        clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  data_i,
   input  wire logic        wr_i,
   output logic      [15:0] last_addr_o,
   output logic      [7:0]  last_data_o
);
   always_ff @(posedge clk_i)
   begin
      if (wr_i)
      begin
         last_addr_o <= addr_i;
         last_data_o <= data_i;
      end
   end
endmodule : srctl_ext_model

// File: tb/tb.sv
// Self-checking bench for the standby RAM control.
// Assumes the checker binds itself and the external model captures write misses.
`timescale 1ns/1ps
module tb;
   logic        clk, rst_n, por_n, wr, rd, mw, mr, ih, sh, ew, er, good, low, en, fl;
   logic [7:0]  ra, wd, rdat, md, mdat, ed, xd;
   logic [15:0] ma, ea, xa;
   logic [2:0]  mode, mo;
   int          errors, checks_done;
   srctl_top u_dut
   (
      .CLOCK_I(clk), .RST_N_I(rst_n), .STBY_POR_N_I(por_n), .REG_ADDR_I(ra),
      .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
      .MEM_ADDR_I(ma), .MEM_WDATA_I(md), .MEM_WR_I(mw), .MEM_RD_I(mr),
      .MEM_RDATA_O(mdat), .MEM_INT_HIT_O(ih), .MEM_STBY_HIT_O(sh), .EXT_ADDR_O(ea),
      .EXT_WDATA_O(ed), .EXT_WR_O(ew), .EXT_RD_O(er), .STBY_GOOD_I(good),
      .STBY_LOW_I(low), .MODE_PINS_I(mode), .RAM_ENABLE_O(en),
      .STANDBY_VALID_O(fl), .MODE_O(mo)
   );
   srctl_ext_model u_ext
   (
      .clk_i(clk), .addr_i(ea), .data_i(ed), .wr_i(ew), .last_addr_o(xa), .last_data_o(xd)
   );
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      checks_done++;
      if (s !== e)
      begin
         errors++;
         $display("mismatch %0t %h %h", $time, s, e);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic rw(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : rw
   task automatic rr(input logic [7:0] a, output logic [7:0] q);
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdat;
   endtask : rr
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      ma <= a;
      md <= d;
      mw <= w;
      mr <= !w;
      @(posedge clk);
      mw <= 1'b0;
      mr <= 1'b0;
      #1;
   endtask : acc
   // Pins held well past the filter delay before release
   task automatic boot(input logic g, input logic [2:0] m);
      cyc(1);
      good <= g;
      mode <= m;
      rst_n <= 1'b0;
      cyc(7);
      rst_n <= 1'b1;
      cyc(1);
      #1;
   endtask : boot
   task automatic sc_regs;
      logic [7:0] q;
      rw(8'h14, 8'hff);
      rr(8'h14, q);
      chk(q, 8'hc0);
      cyc(1);
      #1 chk(rdat, 8'h00);
      rw(8'h15, 8'h00);
      rr(8'h15, q);
      chk({q, 7'h00, en}, 16'h0001);
      rw(8'h14, 8'h40);
      rr(8'h14, q);
      chk(q, 8'h40);
   endtask : sc_regs
   task automatic sc_ram;
      acc(1'b1, 16'h0085, 8'h5a);
      chk({ih, sh, ew}, 3'b110);
      acc(1'b1, 16'h00c0, 8'h33);
      chk({ih, sh}, 2'b10);
      rw(8'h14, 8'h00);
      acc(1'b1, 16'h0085, 8'h11);
      chk({ih, ew, ea}, {2'b01, 16'h0085});
      cyc(1);
      #1 chk({xa, xd}, {16'h0085, 8'h11});
      rw(8'h14, 8'h40);
      acc(1'b0, 16'h0085, 8'h00);
      chk({ih, mdat}, {1'b1, 8'h5a});
   endtask : sc_ram
   task automatic sc_boot;
      boot(1'b1, 3'h0);
      chk({fl, en}, 2'b01);
   endtask : sc_boot
   task automatic sc_flag;
      rw(8'h14, 8'h80);
      boot(1'b0, 3'h0);
      chk({fl, en}, 2'b10);
   endtask : sc_flag
   task automatic sc_low;
      logic [7:0] q;
      cyc(1);
      low <= 1'b1;
      cyc(8);
      #1 chk(fl, 1'b0);
      rw(8'h14, 8'hc0);
      rr(8'h14, q);
      chk(q, 8'h40);
      cyc(1);
      low <= 1'b0;
      cyc(8);
      rw(8'h14, 8'hc0);
      rr(8'h14, q);
      chk(q, 8'hc0);
   endtask : sc_low
   task automatic sc_mode3;
      rw(8'h14, 8'h00);
      boot(1'b1, 3'h3);
      chk({mo, en}, 4'h7);
      acc(1'b0, 16'h0085, 8'h00);
      chk({ih, er}, 2'b01);
   endtask : sc_mode3
   task automatic report_and_stop;
      if (errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   initial
   begin
      {rst_n, por_n, ra, wd, wr, rd, ma, md, mw, mr, low, mode} <= '0;
      good <= 1'b1;
      errors = 0;
      checks_done = 0;
      cyc(3);
      por_n <= 1'b1;
      sc_boot();
      sc_regs();
      sc_ram();
      sc_flag();
      sc_low();
      sc_mode3();
      report_and_stop();
   end
endmodule : tb
